// [inc/prc_led_if.sv]
/*
 interface carrying link status to the example led logic.
 assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface prc_led_if;
    logic [4:0] ltssm;
    logic revision_sel;
    logic led;
    modport ctrl (output ltssm, output revision_sel, input led);
    modport led_end (input ltssm, input revision_sel, output led);
endinterface : prc_led_if
`default_nettype wire

// [inc/prc_pkg.sv]
/*
 package for the link core release sequencer: states, counts, reset values.
 assumes nothing beyond a single clock domain.
*/
package prc_pkg;
    typedef enum logic [2:0] {
        PRC_ST_WAIT_PERIPH,
        PRC_ST_HOLD,
        PRC_ST_RETRY,
        PRC_ST_NORMAL,
        PRC_ST_RESTART
    } prc_state_t;
    typedef enum logic [1:0] {
        PRC_RESP_NONE,
        PRC_RESP_RETRY,
        PRC_RESP_NORMAL
    } prc_resp_t;
    localparam int PRC_LED_BIT = 23;
    localparam int PRC_CNT_W = 24;
    localparam int PRC_RESTART_CYCLES = 16;
    localparam logic [4:0] PRC_LTSSM_POLL_COMPL = 5'h03;
    localparam logic PRC_RST_LED = 1'b0;
    localparam logic PRC_RST_CORE_RESET = 1'b1;
endpackage : prc_pkg

// [src/prc_core_release.sv]
/*
 release sequencer for the hardened link core during configuration.
 assumes config controller status inputs are pin-level and asynchronous.
*/
// Function
// RULE1: with auto restart selected, a configuration error restarts link configuration.
// RULE2: link configuration enabled forces autonomous release after periphery load.
// RULE3: link configuration enabled: released core answers requests with successful completion.
// RULE4: core image travels over the link in initialization and update modes.
// RULE5: other path plus autonomous: release core once periphery image loads.
// RULE6: that case answers config with retry status, memory unsupported, until user mode.
// RULE7: other path without autonomous: core held in reset until user mode.
// RULE8: non-autonomous case: link training waits for user mode.
// RULE9: autonomous option only affects initial configuration, not later updates.
// RULE10: base revision led lights when training enters polling compliance.
// RULE11: updated revision led follows bit 23 of a free-running counter.
// RULE12: update mode drives a dedicated open-drain core configuration done pin.
// RULE13: user-mode and path-select inputs choose hold, retry or normal behaviour.
`timescale 1ns/1ps
`default_nettype none
module prc_core_release #(
    parameter int CNT_W = prc_pkg::PRC_CNT_W,
    parameter int LED_BIT = prc_pkg::PRC_LED_BIT
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic PERIPH_LOADED,
    input wire logic USER_MODE,
    input wire logic CONFIG_ERROR,
    input wire logic LINK_CONFIG_EN,
    input wire logic AUTONOMOUS_SEL,
    input wire logic AUTO_RESTART_SEL,
    input wire logic UPDATE_MODE,
    input wire logic REVISION_SEL,
    input wire logic [4:0] LTSSM_STATE,
    output logic CORE_RESET,
    output logic TRAINING_ENABLE,
    output prc_pkg::prc_resp_t RESP_MODE,
    output logic CONFIG_RESTART,
    output logic CORE_CONFIG_DONE_PIN_O,
    output logic CORE_CONFIG_DONE_PIN_OE,
    output logic LED
);
    import prc_pkg::*;
    localparam int N_SYNC = 8;
    wire [N_SYNC-1:0] pin_raw = {
        REVISION_SEL,
        UPDATE_MODE,
        LINK_CONFIG_EN,
        AUTO_RESTART_SEL,
        AUTONOMOUS_SEL,
        CONFIG_ERROR,
        USER_MODE,
        PERIPH_LOADED
    };
    wire [N_SYNC-1:0] sync_b;
    prc_state_t state;
    prc_state_t next_state;
    logic initial_done;
    logic [4:0] restart_cnt;
    logic core_reset;
    logic train_en;
    prc_resp_t resp;
    logic done_oe;
    logic restart_flag;
    prc_led_if lif ();

    // synced pin aliases
    wire periph_s = sync_b[0];
    wire user_s = sync_b[1];
    wire err_s = sync_b[2];
    wire auto_s = sync_b[3];
    wire restart_s = sync_b[4];
    wire link_s = sync_b[5];
    wire update_s = sync_b[6];
    wire revision_s = sync_b[7];
    wire autonomous_eff = link_s | auto_s; // RULE2
    wire use_autonomous = autonomous_eff & ~initial_done; // RULE9
    wire restart_hit = err_s & restart_s; // RULE1
    wire restart_over = (restart_cnt == 5'(PRC_RESTART_CYCLES - 1));

    // next-state logic
    always_comb begin
        next_state = state;
        case (state)
            PRC_ST_WAIT_PERIPH: begin
                if (periph_s) begin
                    if (use_autonomous | initial_done) begin
                        next_state = (link_s | user_s) ? PRC_ST_NORMAL : PRC_ST_RETRY; // RULE5 RULE13
                    end else begin
                        next_state = user_s ? PRC_ST_NORMAL : PRC_ST_HOLD; // RULE7
                    end
                end
            end
            PRC_ST_HOLD: begin
                if (user_s) begin
                    next_state = PRC_ST_NORMAL; // RULE7 RULE8
                end
            end
            PRC_ST_RETRY: begin
                if (user_s) begin
                    next_state = PRC_ST_NORMAL; // RULE6
                end
            end
            PRC_ST_NORMAL: begin
                next_state = PRC_ST_NORMAL;
            end
            PRC_ST_RESTART: begin
                if (restart_over) begin
                    next_state = PRC_ST_WAIT_PERIPH; // RULE1
                end
            end
            default: begin
                next_state = PRC_ST_WAIT_PERIPH;
            end
        endcase
        if (restart_hit && state != PRC_ST_RESTART) begin
            next_state = PRC_ST_RESTART; // RULE1
        end
    end

    // output decodes
    wire next_core_reset = (next_state == PRC_ST_WAIT_PERIPH) | (next_state == PRC_ST_HOLD)
        | (next_state == PRC_ST_RESTART); // RULE7
    wire next_train = (next_state == PRC_ST_RETRY) | (next_state == PRC_ST_NORMAL); // RULE8
    wire prc_resp_t next_resp = (next_state == PRC_ST_NORMAL) ? PRC_RESP_NORMAL // RULE3
        : (next_state == PRC_ST_RETRY) ? PRC_RESP_RETRY : PRC_RESP_NONE; // RULE6
    wire next_done_oe = update_s & ~user_s; // RULE12
    wire next_restart = (next_state == PRC_ST_RESTART); // RULE1

    // two-stage pin synchronisers
    for (genvar g = 0; g < N_SYNC; g++) begin : g_sync
        logic stage_a;
        logic stage_b;
        always_ff @(posedge CLK) begin
            if (SRST) begin
                stage_a <= 1'b0;
                stage_b <= 1'b0;
            end else begin
                stage_a <= pin_raw[g];
                stage_b <= stage_a;
            end
        end
        assign sync_b[g] = stage_b;
    end

    // state register
    always_ff @(posedge CLK) begin
        if (SRST) begin
            state <= PRC_ST_WAIT_PERIPH;
        end else begin
            state <= next_state;
        end
    end

    // registered outputs
    always_ff @(posedge CLK) begin
        if (SRST) begin
            core_reset <= PRC_RST_CORE_RESET;
        end else begin
            core_reset <= next_core_reset;
        end
    end
    always_ff @(posedge CLK) begin
        if (SRST) begin
            train_en <= 1'b0;
        end else begin
            train_en <= next_train;
        end
    end
    always_ff @(posedge CLK) begin
        if (SRST) begin
            resp <= PRC_RESP_NONE;
        end else begin
            resp <= next_resp;
        end
    end
    always_ff @(posedge CLK) begin
        if (SRST) begin
            done_oe <= 1'b0;
        end else begin
            done_oe <= next_done_oe;
        end
    end
    always_ff @(posedge CLK) begin
        if (SRST) begin
            restart_flag <= 1'b0;
        end else begin
            restart_flag <= next_restart;
        end
    end

    // first-configuration marker
    always_ff @(posedge CLK) begin
        if (SRST) begin
            initial_done <= 1'b0;
        end else if (state == PRC_ST_NORMAL) begin
            initial_done <= 1'b1; // RULE9
        end
    end
    // restart length counter
    always_ff @(posedge CLK) begin
        if (SRST || state != PRC_ST_RESTART) begin
            restart_cnt <= '0;
        end else begin
            restart_cnt <= restart_cnt + 5'h01;
        end
    end
    // core image over the link: link config enable marks that path, status taken from the link core
    assign lif.ltssm = LTSSM_STATE; // RULE4
    assign lif.revision_sel = revision_s;
    prc_user_led #(
        .CNT_W(CNT_W),
        .LED_BIT(LED_BIT)
    ) u_led (
        .CLK(CLK),
        .SRST(SRST),
        .lif(lif)
    );

    // port drives
    assign CORE_RESET = core_reset;
    assign TRAINING_ENABLE = train_en;
    assign RESP_MODE = resp;
    assign CONFIG_RESTART = restart_flag;
    assign CORE_CONFIG_DONE_PIN_O = 1'b0; // RULE12
    assign CORE_CONFIG_DONE_PIN_OE = done_oe;
    assign LED = lif.led;
endmodule : prc_core_release
`default_nettype wire

// [src/prc_user_led.sv]
/*
 example status led: base revision lights on polling compliance,
 updated revision lights from a free-running counter bit.
 assumes inputs already synchronous to CLK.
*/
`timescale 1ns/1ps
`default_nettype none
module prc_user_led #(
    parameter int CNT_W = prc_pkg::PRC_CNT_W,
    parameter int LED_BIT = prc_pkg::PRC_LED_BIT
) (
    input wire logic CLK,
    input wire logic SRST,
    prc_led_if.led_end lif
);
    import prc_pkg::*;
    logic [CNT_W-1:0] count;
    logic led_q;
    wire in_compliance = (lif.ltssm == PRC_LTSSM_POLL_COMPL);
    wire next_led = lif.revision_sel ? count[LED_BIT] : in_compliance; // RULE10 RULE11
    always_ff @(posedge CLK) begin
        if (SRST) begin
            count <= '0;
            led_q <= PRC_RST_LED;
        end else begin
            count <= count + 1'b1; // RULE11
            led_q <= next_led;
        end
    end
    assign lif.led = led_q;
endmodule : prc_user_led
`default_nettype wire

// [verification/prc_core_release_bench.sv]
/* self-checking bench for the release sequencer and host model.
 assumes the 3-cycle input latency of the sequencer. */
`timescale 1ns/1ps
`default_nettype none
module prc_core_release_bench;
    import prc_pkg::*;
    logic CLK = 0, SRST = 1, pl = 0, um = 0, ce = 0, le = 0, au = 0, ar = 0, up = 0, rv = 0, go = 0, rel;
    logic cr, te, rs, po, oe, led;
    logic [4:0] lt;
    prc_resp_t rm;
    // low led bit so the counter led toggles within a short run
    localparam int LB = 1;
    int mismatches = 0, n_tests = 0, seen = 0, k, cyc = 0;
    always #2 CLK = ~CLK;
    always @(posedge CLK) cyc <= SRST ? 0 : cyc + 1;
    prc_host_model i_host (.CLK(CLK), .train_en(te), .compl(go), .ltssm(lt));
    prc_core_release #(.LED_BIT(LB)) i_dut (.CLK(CLK), .SRST(SRST), .PERIPH_LOADED(pl), .USER_MODE(um),
        .CONFIG_ERROR(ce),
        .LINK_CONFIG_EN(le), .AUTONOMOUS_SEL(au), .AUTO_RESTART_SEL(ar), .UPDATE_MODE(up), .REVISION_SEL(rv),
        .LTSSM_STATE(lt), .CORE_RESET(cr), .TRAINING_ENABLE(te), .RESP_MODE(rm), .CONFIG_RESTART(rs),
        .CORE_CONFIG_DONE_PIN_O(po), .CORE_CONFIG_DONE_PIN_OE(oe), .LED(led));
    task automatic chk(input string n, input logic [1:0] s, input logic [1:0] e);
        n_tests++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s exp %0h got %0h", n, e, s);
        end
    endtask : chk
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done
    task automatic step(input int c);
        repeat (c) @(negedge CLK);
    endtask : step
    task automatic rst;
        SRST = 1;
        seen = 0;
        step(4);
        SRST = 0;
    endtask : rst
    task automatic wait_rs(input logic v, output int n);
        n = 0;
        while (rs !== v) begin
            step(1);
            n++;
            if (n > 40) begin
                mismatches++;
                test_done;
            end
        end
    endtask : wait_rs
    task automatic model;
        step(4);
        rel = pl && (um || le || au || seen != 0);
        if (pl && (um || le)) seen = 1;
        chk("core_reset", cr, !rel);
        chk("training", te, rel);
        chk("resp", rm, !rel ? PRC_RESP_NONE : (um || le) ? PRC_RESP_NORMAL : PRC_RESP_RETRY);
        chk("done_oe", oe, up && !um);
        chk("done_o", po, 1'b0);
    endtask : model
    initial begin
        k = $urandom(32'h9095);
        for (int i = 0; i < 12; i++) begin
            {le, au, up, rv} = 4'($urandom);
            le = le && (i % 3 == 0);
            {pl, um, ce, go, ar} = 5'h00;
            rst;
            model;
            pl = 1;
            model;
            go = 1;
            step(2);
            for (int j = 0; j < 4; j++) begin
                step(1);
                chk("led", led, rv ? 1'((cyc - 1) >> LB) : rel);
            end
            um = 1;
            model;
        end
        {le, au, ar, up, pl, um, go} = 7'h10;
        rst;
        pl = 1;
        model;
        um = 1;
        model;
        ce = 1;
        wait_rs(1, k);
        ce = 0;
        um = 0;
        wait_rs(0, k);
        chk("restart_len", k == PRC_RESTART_CYCLES, 1'b1);
        model;
        ar = 0;
        step(4);
        ce = 1;
        step(5);
        chk("no_restart", rs, 1'b0);
        test_done;
    end
endmodule : prc_core_release_bench
`default_nettype wire

// [verification/prc_core_release_chk.sv]
/* port assertions for the release sequencer.
 assumes bound to prc_core_release, inputs act 3 edges later. */
`timescale 1ns/1ps
`default_nettype none
module prc_core_release_chk (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic PERIPH_LOADED,
    input wire logic USER_MODE,
    input wire logic CONFIG_ERROR,
    input wire logic LINK_CONFIG_EN,
    input wire logic AUTONOMOUS_SEL,
    input wire logic AUTO_RESTART_SEL,
    input wire logic UPDATE_MODE,
    input wire logic REVISION_SEL,
    input wire logic [4:0] LTSSM_STATE,
    input wire logic CORE_RESET,
    input wire logic TRAINING_ENABLE,
    input wire logic CONFIG_RESTART,
    input wire logic CORE_CONFIG_DONE_PIN_O,
    input wire logic CORE_CONFIG_DONE_PIN_OE,
    input wire logic LED,
    input wire prc_pkg::prc_resp_t RESP_MODE
);
    import prc_pkg::*;
    logic seen;
    always_ff @(posedge CLK) begin
        if (SRST) seen <= 1'b0;
        else if (RESP_MODE == PRC_RESP_NORMAL) seen <= 1'b1;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    sequence s_held;
        !seen && RESP_MODE != PRC_RESP_NORMAL && !LINK_CONFIG_EN && !$past(AUTONOMOUS_SEL, 3) && !$past(USER_MODE, 3);
    endsequence
    sequence s_up;
        $rose(PERIPH_LOADED) && (AUTONOMOUS_SEL || LINK_CONFIG_EN) && !USER_MODE && !CONFIG_ERROR && !CONFIG_RESTART;
    endsequence
    a_hold_no_auto: assert property (s_held |-> CORE_RESET)
        else $error("core left reset early");
    a_train_waits: assert property (s_held |-> !TRAINING_ENABLE)
        else $error("training before user mode");
    a_release_auto: assert property (s_up |-> ##3 !CORE_RESET && ((RESP_MODE == PRC_RESP_RETRY) != LINK_CONFIG_EN))
        else $error("no release after periphery");
    a_retry_user: assert property (RESP_MODE == PRC_RESP_RETRY |-> !LINK_CONFIG_EN && !$past(USER_MODE, 3))
        else $error("retry answer out of place");
    a_link_normal: assert property (LINK_CONFIG_EN && !CORE_RESET |-> RESP_MODE == PRC_RESP_NORMAL)
        else $error("link config answer not normal");
    a_user_normal: assert property ($rose(USER_MODE) && PERIPH_LOADED && !CONFIG_ERROR && !CONFIG_RESTART
        |-> ##3 RESP_MODE == PRC_RESP_NORMAL && !CORE_RESET) else $error("no normal answer in user mode");
    a_err_restart: assert property ($rose(CONFIG_ERROR) && AUTO_RESTART_SEL && !CONFIG_RESTART
        |-> ##3 CONFIG_RESTART[*8]) else $error("no restart after error");
    a_no_restart: assert property ($rose(CONFIG_ERROR) && !AUTO_RESTART_SEL |-> ##3 !CONFIG_RESTART)
        else $error("restart without option");
    a_done_pin: assert property (CORE_CONFIG_DONE_PIN_OE |-> UPDATE_MODE && !CORE_CONFIG_DONE_PIN_O)
        else $error("done pin misdriven");
    a_led_compl: assert property (!REVISION_SEL && LTSSM_STATE == PRC_LTSSM_POLL_COMPL |=> LED)
        else $error("led dark in compliance");
endmodule : prc_core_release_chk
bind prc_core_release prc_core_release_chk i_chk (.CLK(CLK), .SRST(SRST), .PERIPH_LOADED(PERIPH_LOADED),
    .USER_MODE(USER_MODE), .CONFIG_ERROR(CONFIG_ERROR), .LINK_CONFIG_EN(LINK_CONFIG_EN),
    .AUTONOMOUS_SEL(AUTONOMOUS_SEL), .AUTO_RESTART_SEL(AUTO_RESTART_SEL), .UPDATE_MODE(UPDATE_MODE),
    .REVISION_SEL(REVISION_SEL), .LTSSM_STATE(LTSSM_STATE), .CORE_RESET(CORE_RESET),
    .TRAINING_ENABLE(TRAINING_ENABLE), .CONFIG_RESTART(CONFIG_RESTART), .LED(LED), .RESP_MODE(RESP_MODE),
    .CORE_CONFIG_DONE_PIN_O(CORE_CONFIG_DONE_PIN_O), .CORE_CONFIG_DONE_PIN_OE(CORE_CONFIG_DONE_PIN_OE));
`default_nettype wire

// [verification/prc_host_model.sv]
/* host side link model: walks the training state.
 assumes one clock shared with the sequencer. */
`timescale 1ns/1ps
`default_nettype none
module prc_host_model (
    input wire logic CLK,
    input wire logic train_en,
    input wire logic compl,
    output logic [4:0] ltssm
);
    always_ff @(posedge CLK) begin
        ltssm <= !train_en ? 5'h00 : compl ? prc_pkg::PRC_LTSSM_POLL_COMPL : 5'h01;
    end
endmodule : prc_host_model
`default_nettype wire
